// ---- hw/ucp_host_port.sv ----
`timescale 1ns/1ps
// How it works
// - A write with addr_data_select low loads the address pointer; cycles with it high access the pointed location.
// - The port is an 8-bit two-way data bus, a low chip select, low read and write strobes and one address-select line.
// - An access ends as soon as its strobe, or the chip select (processor) or the acknowledge (DMA), goes inactive, whichever is first.
// - Each processor data access with addr_data_select high advances the pointer by one; DMA cycles leave it alone.
// - In host mode the lowest 16 bytes are registers and the other 240 bytes are buffer space.
// - In peripheral mode the lowest 64 bytes are registers and the other 192 bytes are buffer space.
// - In peripheral mode only, DMA moves bytes using a low request output, a low acknowledge and the strobes.
// - A programmable count register sets how many bytes the DMA handshake runs for.
// - One interrupt output is high while any enabled event is pending; pending events read in a status register.
// - Writing the status register clears pending bits, and the interrupt drops once no enabled event remains.
// - Incoming USB data goes to the buffer region whose start and size software programmed.
// - The core clock uses the PLL unless pll_bypass_select is held at 0, which bypasses it.
module ucp_host_port
(
	input  wire logic                             sys_clk,
	input  wire logic                             rst,
	input  wire logic [7:0]                       data_in,
	output logic      [7:0]                       data_out,
	output logic                                  data_oe_low,
	input  wire logic                             chip_select_low,
	input  wire logic                             read_strobe_low,
	input  wire logic                             write_strobe_low,
	input  wire logic                             addr_data_select,
	input  wire logic                             dma_acknowledge_low,
	output logic                                  dma_request_low,
	output logic                                  irq_output,
	input  wire logic                             pll_bypass_select,
	output logic                                  pll_enable,
	input  wire logic                             peripheral_mode,
	input  wire logic [ucp_pkg::USB_EVENT_W-1:0]  usb_event,
	input  wire logic                             sie_rx_start,
	input  wire logic                             sie_rx_valid,
	input  wire logic [7:0]                       sie_rx_data,
	output logic                                  sie_rx_ready
);

	ucp_pkg::ucp_state_t q_ff;
	ucp_pkg::ucp_state_t nxt_q;

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb
	begin
		logic       cpu_wr;
		logic       cpu_rd;
		logic       dma_wr;
		logic       dma_rd;
		logic       mem_we;
		logic [7:0] mem_a;
		logic [7:0] mem_d;
		logic [7:0] set_v;
		logic [7:0] clr_v;
		logic [7:0] reg_limit;
		logic [7:0] stat_off;
		logic [7:0] ien_off;
		logic [7:0] rd_addr;
		logic [7:0] rd_val;
		logic       push;
		logic       pop;
		nxt_q = q_ff;
		mem_we = 1'b0;
		mem_a = 8'h00;
		mem_d = 8'h00;
		set_v = {2'b00, usb_event};
		clr_v = 8'h00;
		cpu_wr = 1'b0;
		cpu_rd = 1'b0;
		dma_wr = 1'b0;
		dma_rd = 1'b0;
		rd_addr = 8'h00;
		rd_val = 8'h00;
		push = 1'b0;
		pop = 1'b0;
		reg_limit = peripheral_mode ? ucp_pkg::PERI_REG_LIMIT : ucp_pkg::HOST_REG_LIMIT;
		stat_off = peripheral_mode ? ucp_pkg::PERI_STAT_OFF : ucp_pkg::HOST_STAT_OFF;
		ien_off = peripheral_mode ? ucp_pkg::PERI_IEN_OFF : ucp_pkg::HOST_IEN_OFF;

		// Two stages on every bus, DMA acknowledge and PLL select pin before any logic looks at it
		nxt_q.cs_m = chip_select_low;
		nxt_q.cs_s = q_ff.cs_m;
		nxt_q.wr_m = write_strobe_low;
		nxt_q.wr_s = q_ff.wr_m;
		nxt_q.rd_m = read_strobe_low;
		nxt_q.rd_s = q_ff.rd_m;
		nxt_q.a0_m = addr_data_select;
		nxt_q.a0_s = q_ff.a0_m;
		nxt_q.dack_m = dma_acknowledge_low;
		nxt_q.dack_s = q_ff.dack_m;
		nxt_q.byp_m = pll_bypass_select;
		nxt_q.byp_s = q_ff.byp_m;
		nxt_q.din_m = data_in;
		nxt_q.din_s = q_ff.din_m;

		// Either strobe, or chip select (processor) or acknowledge (DMA), going high closes the access
		cpu_wr = ~q_ff.cs_s & ~q_ff.wr_s & q_ff.dack_s;
		cpu_rd = ~q_ff.cs_s & ~q_ff.rd_s & q_ff.dack_s;
		dma_wr = peripheral_mode & ~q_ff.dack_s & ~q_ff.wr_s;
		dma_rd = peripheral_mode & ~q_ff.dack_s & ~q_ff.rd_s;
		nxt_q.cpu_wr_act = cpu_wr;
		nxt_q.cpu_rd_act = cpu_rd;
		nxt_q.dma_wr_act = dma_wr;
		nxt_q.dma_rd_act = dma_rd;
		if (cpu_wr | dma_wr)
		begin
			nxt_q.wdata = q_ff.din_s;
		end
		if (cpu_wr | cpu_rd)
		begin
			nxt_q.a0_l = q_ff.a0_s;
		end

		// Processor write committed on its trailing edge
		if (q_ff.cpu_wr_act & ~cpu_wr)
		begin
			if (!q_ff.a0_l)
			begin
				nxt_q.ptr = q_ff.wdata;
			end
			else
			begin
				mem_we = 1'b1;
				mem_a = q_ff.ptr;
				mem_d = q_ff.wdata;
				nxt_q.ptr = q_ff.ptr + 8'h01;
				if (q_ff.ptr == stat_off)
				begin
					clr_v = q_ff.wdata;
				end
				if (peripheral_mode && q_ff.ptr == ucp_pkg::DMA_CTL_OFF)
				begin
					nxt_q.dma_en = q_ff.wdata[ucp_pkg::DMA_CTL_EN];
					nxt_q.dma_ptr = q_ff.mem[ucp_pkg::DMA_ADDR_OFF];
					nxt_q.dma_cnt = q_ff.mem[ucp_pkg::DMA_CNT_OFF];
				end
			end
		end
		if (q_ff.cpu_rd_act & ~cpu_rd & q_ff.a0_l)
		begin
			nxt_q.ptr = q_ff.ptr + 8'h01;
		end

		// DMA byte, one per acknowledged strobe, until the count runs out
		if (q_ff.dma_en & q_ff.dma_cnt != 8'h00 &
			((q_ff.dma_wr_act & ~dma_wr) | (q_ff.dma_rd_act & ~dma_rd)))
		begin
			if (q_ff.dma_wr_act)
			begin
				mem_we = 1'b1;
				mem_a = q_ff.dma_ptr;
				mem_d = q_ff.wdata;
			end
			nxt_q.dma_ptr = q_ff.dma_ptr + 8'h01;
			nxt_q.dma_cnt = q_ff.dma_cnt - 8'h01;
			if (q_ff.dma_cnt == 8'h01)
			begin
				nxt_q.dma_en = 1'b0;
				set_v[ucp_pkg::STAT_DMA_DONE] = 1'b1;
			end
		end

		// Read data; live status and count win over the stored byte
		rd_addr = dma_rd ? q_ff.dma_ptr : q_ff.ptr;
		if (rd_addr == stat_off)
		begin
			rd_val = q_ff.status;
		end
		else if (peripheral_mode && rd_addr == ucp_pkg::DMA_CNT_OFF)
		begin
			rd_val = q_ff.dma_cnt;
		end
		else
		begin
			rd_val = q_ff.mem[rd_addr];
		end
		if (dma_rd | (cpu_rd & q_ff.a0_s))
		begin
			nxt_q.data_out = rd_val;
		end
		else if (cpu_rd)
		begin
			nxt_q.data_out = q_ff.ptr;
		end
		nxt_q.data_oe_low = ~(cpu_rd | dma_rd);

		// ************************************************************
		// USB receive path through the two-entry buffer
		// ************************************************************
		push = sie_rx_valid & q_ff.rx_ready;
		pop = (q_ff.fifo_cnt != 2'h0) & ~mem_we;
		if (push)
		begin
			nxt_q.fifo_data[q_ff.fifo_wp] = sie_rx_data;
			nxt_q.fifo_wp = ~q_ff.fifo_wp;
		end
		if (pop)
		begin
			nxt_q.fifo_rp = ~q_ff.fifo_rp;
			if (q_ff.rx_left != 8'h00)
			begin
				// Bytes aimed at register space are dropped to protect control state
				if (q_ff.rx_ptr >= reg_limit)
				begin
					mem_we = 1'b1;
					mem_a = q_ff.rx_ptr;
					mem_d = q_ff.fifo_data[q_ff.fifo_rp];
				end
				nxt_q.rx_ptr = q_ff.rx_ptr + 8'h01;
				nxt_q.rx_left = q_ff.rx_left - 8'h01;
				if (q_ff.rx_left == 8'h01)
				begin
					set_v[ucp_pkg::STAT_RX_DONE] = 1'b1;
				end
			end
		end
		if (sie_rx_start)
		begin
			nxt_q.rx_ptr = q_ff.mem[ucp_pkg::RX_BASE_OFF];
			nxt_q.rx_left = q_ff.mem[ucp_pkg::RX_LEN_OFF];
		end
		nxt_q.fifo_cnt = q_ff.fifo_cnt + {1'b0, push} - {1'b0, pop};
		nxt_q.rx_ready = (nxt_q.fifo_cnt != ucp_pkg::FIFO_FULL_CNT);

		if (mem_we)
		begin
			nxt_q.mem[mem_a] = mem_d;
		end

		// A new event in the clearing cycle survives the clear
		nxt_q.status = (q_ff.status & ~clr_v) | set_v;
		nxt_q.irq = |(nxt_q.status & nxt_q.mem[ien_off]);
		nxt_q.dma_req_low = ~(peripheral_mode & nxt_q.dma_en & nxt_q.dma_cnt != 8'h00);
		nxt_q.pll_enable = q_ff.byp_s;
	end

	// ************************************************************
	// State register
	// ************************************************************
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			q_ff <= '0;
			q_ff.cs_m <= ucp_pkg::PIN_IDLE_HIGH;
			q_ff.cs_s <= ucp_pkg::PIN_IDLE_HIGH;
			q_ff.wr_m <= ucp_pkg::PIN_IDLE_HIGH;
			q_ff.wr_s <= ucp_pkg::PIN_IDLE_HIGH;
			q_ff.rd_m <= ucp_pkg::PIN_IDLE_HIGH;
			q_ff.rd_s <= ucp_pkg::PIN_IDLE_HIGH;
			q_ff.dack_m <= ucp_pkg::PIN_IDLE_HIGH;
			q_ff.dack_s <= ucp_pkg::PIN_IDLE_HIGH;
			q_ff.byp_m <= ucp_pkg::PIN_IDLE_HIGH;
			q_ff.byp_s <= ucp_pkg::PIN_IDLE_HIGH;
			q_ff.data_oe_low <= ucp_pkg::PIN_IDLE_HIGH;
			q_ff.dma_req_low <= ucp_pkg::PIN_IDLE_HIGH;
			q_ff.pll_enable <= ucp_pkg::PIN_IDLE_HIGH;
		end
		else
		begin
			q_ff <= nxt_q;
		end
	end

	assign data_out        = q_ff.data_out;
	assign data_oe_low     = q_ff.data_oe_low;
	assign dma_request_low = q_ff.dma_req_low;
	assign irq_output      = q_ff.irq;
	assign pll_enable      = q_ff.pll_enable;
	assign sie_rx_ready    = q_ff.rx_ready;

endmodule

// ---- hw/ucp_pkg.sv ----
package ucp_pkg;

	// ************************************************************
	// Memory map
	// ************************************************************
	localparam int         MEM_DEPTH       = 256;
	localparam logic [7:0] HOST_REG_LIMIT  = 8'h10;
	localparam logic [7:0] PERI_REG_LIMIT  = 8'h40;
	localparam logic [7:0] RX_BASE_OFF     = 8'h01;
	localparam logic [7:0] RX_LEN_OFF      = 8'h02;
	localparam logic [7:0] HOST_IEN_OFF    = 8'h06;
	localparam logic [7:0] HOST_STAT_OFF   = 8'h0d;
	localparam logic [7:0] PERI_IEN_OFF    = 8'h3b;
	localparam logic [7:0] PERI_STAT_OFF   = 8'h3c;
	localparam logic [7:0] DMA_ADDR_OFF    = 8'h3d;
	localparam logic [7:0] DMA_CNT_OFF     = 8'h3e;
	localparam logic [7:0] DMA_CTL_OFF     = 8'h3f;

	// ************************************************************
	// Status bit positions and reset values
	// ************************************************************
	localparam int         USB_EVENT_W     = 6;
	localparam int         STAT_RX_DONE    = 6;
	localparam int         STAT_DMA_DONE   = 7;
	localparam int         DMA_CTL_EN      = 0;
	localparam logic       PIN_IDLE_HIGH   = 1'b1;
	localparam logic [1:0] FIFO_FULL_CNT   = 2'h2;

	// ************************************************************
	// Block state
	// ************************************************************
	typedef struct packed {
		logic [MEM_DEPTH-1:0][7:0] mem;
		logic [7:0]                ptr;
		logic [7:0]                status;
		logic [7:0]                wdata;
		logic                      a0_l;
		logic                      dma_en;
		logic [7:0]                dma_ptr;
		logic [7:0]                dma_cnt;
		logic [7:0]                rx_ptr;
		logic [7:0]                rx_left;
		logic [1:0][7:0]           fifo_data;
		logic [1:0]                fifo_cnt;
		logic                      fifo_wp;
		logic                      fifo_rp;
		logic                      cs_m;
		logic                      cs_s;
		logic                      wr_m;
		logic                      wr_s;
		logic                      rd_m;
		logic                      rd_s;
		logic                      a0_m;
		logic                      a0_s;
		logic                      dack_m;
		logic                      dack_s;
		logic                      byp_m;
		logic                      byp_s;
		logic [7:0]                din_m;
		logic [7:0]                din_s;
		logic                      cpu_wr_act;
		logic                      cpu_rd_act;
		logic                      dma_wr_act;
		logic                      dma_rd_act;
		logic [7:0]                data_out;
		logic                      data_oe_low;
		logic                      dma_req_low;
		logic                      irq;
		logic                      rx_ready;
		logic                      pll_enable;
	} ucp_state_t;

endpackage

// ---- tb/ucp_assertions.sv ----
`timescale 1ns/1ps
module ucp_assertions
(
	input wire logic       sys_clk,
	input wire logic       rst,
	input wire logic [7:0] data_out,
	input wire logic       data_oe_low,
	input wire logic       chip_select_low,
	input wire logic       read_strobe_low,
	input wire logic       write_strobe_low,
	input wire logic       dma_acknowledge_low,
	input wire logic       dma_request_low,
	input wire logic       pll_bypass_select,
	input wire logic       pll_enable,
	input wire logic       peripheral_mode,
	input wire logic       sie_rx_valid,
	input wire logic       sie_rx_ready
);
	// ******
	// Port checks
	// ******
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	oe_idle_a: assert property (read_strobe_low [*4] |-> data_oe_low)
		else $error("bus driven without a read");
	oe_drive_a: assert property ((!chip_select_low && !read_strobe_low) [*5] |-> !data_oe_low)
		else $error("read not driven");
	data_hold_a: assert property (read_strobe_low [*5] |-> $stable(data_out))
		else $error("read data moved");
	req_host_a: assert property (!peripheral_mode [*4] |-> dma_request_low)
		else $error("request in host mode");
	req_fell_a: assert property ($fell(dma_request_low) |-> peripheral_mode)
		else $error("request fell in host mode");
	// Count only moves on an acknowledged strobe, so the request must hold
	req_hold_a: assert property ((dma_acknowledge_low [*4] ##0 !dma_request_low) |=> !dma_request_low)
		else $error("request dropped without transfer");
	rx_ready_a: assert property ((!sie_rx_valid && write_strobe_low) [*6] |-> sie_rx_ready)
		else $error("buffer did not drain");
	pll_follow_a: assert property ($stable(pll_bypass_select) [*5] |-> pll_enable == pll_bypass_select)
		else $error("pll select not followed");
endmodule

bind ucp_host_port ucp_assertions chk (.*);

// ---- tb/ucp_cpu_model.sv ----
`timescale 1ns/1ps
module ucp_cpu_model
(
	input wire logic       sys_clk,
	input wire logic [7:0] data_out,
	input wire logic       data_oe_low,
	output logic           chip_select_low,
	output logic           read_strobe_low,
	output logic           write_strobe_low,
	output logic           addr_data_select,
	output logic           dma_acknowledge_low,
	output logic     [7:0] data_in
);
	// ******
	// Processor bus master
	// ******
	logic       drv = 1'b0;
	logic [7:0] wd  = 8'h00;
	// Released bus shows inverted data so a stale byte never passes
	assign data_in = !data_oe_low ? data_out : (drv ? wd : ~wd);
	initial
	begin
		chip_select_low = 1'b1;
		read_strobe_low = 1'b1;
		write_strobe_low = 1'b1;
		addr_data_select = 1'b0;
		dma_acknowledge_low = 1'b1;
	end
	// One access: a selects address or data, dk makes it a DMA cycle
	task automatic acc(input logic w, a, dk, input logic [7:0] d, output logic [7:0] q);
		@(posedge sys_clk);
		addr_data_select <= a;
		wd <= d;
		drv <= w;
		chip_select_low <= dk;
		dma_acknowledge_low <= !dk;
		write_strobe_low <= !w;
		read_strobe_low <= w;
		repeat (5) @(posedge sys_clk);
		q = data_out;
		write_strobe_low <= 1'b1;
		read_strobe_low <= 1'b1;
		chip_select_low <= 1'b1;
		dma_acknowledge_low <= 1'b1;
		drv <= 1'b0;
		repeat (4) @(posedge sys_clk);
	endtask
endmodule

// ---- tb/usb_ctrl_host_cpu_port_bench.sv ----
`timescale 1ns/1ps
module usb_ctrl_host_cpu_port_bench;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] data_in, data_out, sie_rx_data = 8'h00, q;
	logic data_oe_low, chip_select_low, read_strobe_low, write_strobe_low;
	logic addr_data_select, dma_acknowledge_low, dma_request_low, irq_output;
	logic pll_bypass_select = 1'b1, pll_enable, peripheral_mode = 1'b0;
	logic [ucp_pkg::USB_EVENT_W-1:0] usb_event = '0;
	logic sie_rx_start = 1'b0, sie_rx_valid = 1'b0, sie_rx_ready;
	int num_errors = 0, n_tests = 0;
	typedef struct {logic [7:0] a, d;} ucp_row_t;
	ucp_row_t rows[4] = '{'{8'h10, 8'h80}, '{8'hff, 8'h5a}, '{8'h00, 8'ha5}, '{8'h40, 8'h3c}};
	logic [7:0] rx[2] = '{8'hc1, 8'h2e};

	always #25 sys_clk = ~sys_clk;
	ucp_host_port dut (.*);
	ucp_cpu_model cpu (.*);

	// ******
	// Helpers
	// ******
	task automatic chk(input logic [7:0] g, e);
		n_tests++;
		if (g !== e)
		begin
			num_errors++;
			$display("Error %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wa(input logic [7:0] a);
		cpu.acc(1'b1, 1'b0, 1'b0, a, q);
	endtask
	task automatic wd(input logic [7:0] d);
		cpu.acc(1'b1, 1'b1, 1'b0, d, q);
	endtask
	task automatic rd(input logic [7:0] e);
		cpu.acc(1'b0, 1'b1, 1'b0, 8'h00, q);
		chk(q, e);
	endtask
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ******
	// Tests
	// ******
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		num_errors++;
		final_report();
	end
	initial
	begin
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (2) @(posedge sys_clk);
		chk(data_oe_low, 1'b1);
		chk(dma_request_low, 1'b1);
		chk(irq_output, 1'b0);
		chk(sie_rx_ready, 1'b1);
		$display("reset test done");
		foreach (rows[i])
		begin
			wa(rows[i].a);
			wd(rows[i].d);
			cpu.acc(1'b0, 1'b0, 1'b0, 8'h00, q);
			chk(q, rows[i].a + 8'h01);
			wa(rows[i].a);
			rd(rows[i].d);
		end
		$display("table test done");
		wa(ucp_pkg::HOST_IEN_OFF);
		wd(8'h01);
		usb_event <= 6'h02;
		@(posedge sys_clk);
		usb_event <= 6'h01;
		@(posedge sys_clk);
		usb_event <= '0;
		repeat (3) @(posedge sys_clk);
		chk(irq_output, 1'b1);
		wa(ucp_pkg::HOST_STAT_OFF);
		wd(8'h01);
		repeat (2) @(posedge sys_clk);
		chk(irq_output, 1'b0);
		$display("interrupt test done");
		wa(ucp_pkg::RX_BASE_OFF);
		wd(8'h30);
		wd(8'h02);
		sie_rx_start <= 1'b1;
		@(posedge sys_clk);
		sie_rx_start <= 1'b0;
		foreach (rx[i])
		begin
			sie_rx_valid <= 1'b1;
			sie_rx_data <= rx[i];
			do @(posedge sys_clk); while (sie_rx_ready !== 1'b1);
		end
		sie_rx_valid <= 1'b0;
		wa(8'h30);
		rd(rx[0]);
		rd(rx[1]);
		wa(ucp_pkg::HOST_STAT_OFF);
		rd(8'h42);
		$display("receive test done");
		peripheral_mode <= 1'b1;
		wa(ucp_pkg::DMA_ADDR_OFF);
		wd(8'h80);
		wd(8'h02);
		wd(8'h01);
		chk(dma_request_low, 1'b0);
		cpu.acc(1'b1, 1'b1, 1'b1, 8'haa, q);
		chk(dma_request_low, 1'b0);
		cpu.acc(1'b1, 1'b1, 1'b1, 8'hbb, q);
		chk(dma_request_low, 1'b1);
		wa(8'h80);
		rd(8'haa);
		rd(8'hbb);
		wa(ucp_pkg::DMA_ADDR_OFF);
		wd(8'h80);
		wd(8'h01);
		wd(8'h01);
		chk(dma_request_low, 1'b0);
		cpu.acc(1'b0, 1'b1, 1'b1, 8'h00, q);
		chk(q, 8'haa);
		chk(dma_request_low, 1'b1);
		wa(ucp_pkg::DMA_CNT_OFF);
		rd(8'h00);
		$display("dma test done");
		wa(ucp_pkg::RX_BASE_OFF);
		wd(8'h30);
		wd(8'h01);
		sie_rx_start <= 1'b1;
		@(posedge sys_clk);
		sie_rx_start <= 1'b0;
		sie_rx_valid <= 1'b1;
		sie_rx_data <= 8'h77;
		do @(posedge sys_clk); while (sie_rx_ready !== 1'b1);
		sie_rx_valid <= 1'b0;
		wa(8'h30);
		rd(rx[0]);
		$display("register limit test done");
		pll_bypass_select <= 1'b0;
		repeat (5) @(posedge sys_clk);
		chk(pll_enable, 1'b0);
		$display("pll test done");
		final_report();
	end
endmodule
